// *** rtl/aoc_output_control.v ***
// APB register bank and decode for the converter serial output control words
`include "aoc_map.vh"

module aoc_output_control #(
  parameter SAMPLE_DIV = `AOC_SAMPLE_DIV
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Transmit trigger pin
  input wire transmit_trigger,
  // Serial output controls
  output reg double_rate_merge,
  output reg serial_output_disable,
  output reg serial_output_enable,
  output reg global_power_down,
  output reg [4:0] lane_bit_count,
  output reg [2:0] serialization_rate,
  output reg rate_code_unused,
  // Pattern controls
  output reg [2:0] frame_line_pattern_sel,
  output reg frame_line_prbs_sel,
  output reg [2:0] data_line_pattern_sel,
  output reg global_prbs_sel,
  output reg [2:0] data_source,
  output reg [2:0] frame_source,
  // Processing controls
  output reg low_latency_bypass,
  output reg two_channel_average,
  output reg digital_gain_enable,
  output reg digital_offset_enable,
  // Offset correction
  output reg [7:0] offset_start_delay,
  output reg offset_corr_start
);

  // Lane bit count of a rate code, zero for an unused code
  function [4:0] rate_bits;
    input [2:0] code;
    begin
      case (code)
        `AOC_RATE_12X: rate_bits = `AOC_BITS_12X;
        `AOC_RATE_14X: rate_bits = `AOC_BITS_14X;
        `AOC_RATE_16X: rate_bits = `AOC_BITS_16X;
        default: rate_bits = 5'h00;
      endcase
    end
  endfunction

  // True when a pattern code asks for a generated pattern rather than data
  function pattern_active;
    input [2:0] code;
    begin
      case (code)
        `AOC_PAT_NORMAL: pattern_active = 1'b0;
        default: pattern_active = 1'b1;
      endcase
    end
  endfunction

  // Register words
  reg [15:0] output_power_control;
  reg [15:0] pattern_latency_control;
  reg [15:0] serial_rate_gain_offset_control;

  // Trigger synchroniser and edge detector
  reg trig_meta;
  reg trig_sync;
  reg trig_last;
  reg trig_pulse;

  // Sample divider
  reg [7:0] div_count;
  reg sample_en;

  // Counter of accepted triggers for status
  reg [7:0] trigger_count;

  // Delay engine
  wire delay_start;
  wire delay_busy;

  // Bus decode
  wire setup_phase;
  wire access_write;
  wire [3:0] reg_index;
  wire addr_mapped;
  wire [15:0] wr_word;
  wire [15:0] wr_mask;
  wire [7:0] delay_word;

  // Bus decode: misaligned or out-of-range addresses are refused with an error
  assign setup_phase = psel & ~penable;
  assign access_write = psel & penable & pready & pwrite & ~pslverr;
  assign reg_index = paddr[5:2];
  assign addr_mapped = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
                       ((reg_index == `AOC_IDX_OUTPUT_POWER) ||
                        (reg_index == `AOC_IDX_PATTERN_LATENCY) ||
                        (reg_index == `AOC_IDX_RATE_GAIN_OFFSET) ||
                        (reg_index == `AOC_IDX_STATUS));
  assign wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wr_word = pwdata[15:0];
  assign delay_word = {serial_rate_gain_offset_control[`AOC_W3_DELAY_HI_HI:`AOC_W3_DELAY_HI_LO],
                       pattern_latency_control[`AOC_W2_DELAY_LO_HI:`AOC_W2_DELAY_LO_LO]};

  // Answer one cycle after setup: zero-wait access phase
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase & ~addr_mapped;
    end
  end

  // Read data is captured in the setup cycle
  // Writes, unmapped and misaligned reads return zero
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      if (pwrite || !addr_mapped) begin
        prdata <= 32'h00000000;
      end else begin
        case (reg_index)
          `AOC_IDX_OUTPUT_POWER: prdata <= {16'h0000, output_power_control};
          `AOC_IDX_PATTERN_LATENCY: prdata <= {16'h0000, pattern_latency_control};
          `AOC_IDX_RATE_GAIN_OFFSET: prdata <= {16'h0000, serial_rate_gain_offset_control};
          `AOC_IDX_STATUS: prdata <= {16'h0000, trigger_count, 5'h00, rate_code_unused,
                                      offset_corr_start, delay_busy};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Register writes on the completing access edge, per byte lane
  // Bits outside a word's mask are never stored and read back as zero
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_power_control <= `AOC_W1_RESET;
      pattern_latency_control <= `AOC_W2_RESET;
      serial_rate_gain_offset_control <= `AOC_W3_RESET;
    end else if (access_write) begin
      case (reg_index)
        `AOC_IDX_OUTPUT_POWER: begin
          output_power_control <= (output_power_control & ~(wr_mask & `AOC_W1_MASK)) |
                                  (wr_word & wr_mask & `AOC_W1_MASK);
        end
        `AOC_IDX_PATTERN_LATENCY: begin
          pattern_latency_control <= (pattern_latency_control & ~(wr_mask & `AOC_W2_MASK)) |
                                     (wr_word & wr_mask & `AOC_W2_MASK);
        end
        `AOC_IDX_RATE_GAIN_OFFSET: begin
          serial_rate_gain_offset_control <=
            (serial_rate_gain_offset_control & ~(wr_mask & `AOC_W3_MASK)) |
            (wr_word & wr_mask & `AOC_W3_MASK);
        end
        default: begin
          output_power_control <= output_power_control;
        end
      endcase
    end
  end

  // Two-stage synchroniser on the trigger pin, then rising-edge detect
  // Triggers count only while offset subtraction is on and power is up
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_last <= 1'b0;
      trig_pulse <= 1'b0;
    end else begin
      trig_meta <= transmit_trigger;
      trig_sync <= trig_meta;
      trig_last <= trig_sync;
      trig_pulse <= trig_sync & ~trig_last & digital_offset_enable & ~global_power_down;
    end
  end

  // Sample-rate enable pulse from the core clock
  // Every rate below the core clock is this one-cycle enable
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= 8'h00;
      sample_en <= 1'b0;
    end else if (div_count >= SAMPLE_DIV[7:0] - 8'h01) begin
      div_count <= 8'h00;
      sample_en <= 1'b1;
    end else begin
      div_count <= div_count + 8'h01;
      sample_en <= 1'b0;
    end
  end

  // Triggers accepted, wrapping
  // Read back through the status word for software bookkeeping
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigger_count <= 8'h00;
    end else if (trig_pulse) begin
      trigger_count <= trigger_count + 8'h01;
    end
  end

  // Offset correction start delay
  aoc_start_delay u_start_delay (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sample_en(sample_en),
    .trigger(trig_pulse),
    .delay(delay_word),
    .start(delay_start),
    .busy(delay_busy)
  );

  // Word 1 controls
  // The enable is low while the interface is disabled or powered down
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      double_rate_merge <= 1'b0;
      serial_output_disable <= 1'b0;
      serial_output_enable <= 1'b0;
      global_power_down <= 1'b0;
    end else begin
      double_rate_merge <= output_power_control[`AOC_W1_DOUBLE_RATE];
      serial_output_disable <= output_power_control[`AOC_W1_SERIAL_DISABLE];
      serial_output_enable <= ~output_power_control[`AOC_W1_SERIAL_DISABLE] &
                              ~output_power_control[`AOC_W1_POWER_DOWN];
      global_power_down <= output_power_control[`AOC_W1_POWER_DOWN];
    end
  end

  // Word 2 controls
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_line_pattern_sel <= `AOC_PAT_NORMAL;
      low_latency_bypass <= 1'b0;
      two_channel_average <= 1'b0;
      frame_line_prbs_sel <= 1'b0;
      data_line_pattern_sel <= `AOC_PAT_NORMAL;
      global_prbs_sel <= 1'b0;
    end else begin
      frame_line_pattern_sel <=
        pattern_latency_control[`AOC_W2_FRAME_PAT_HI:`AOC_W2_FRAME_PAT_LO];
      low_latency_bypass <= pattern_latency_control[`AOC_W2_LOW_LATENCY];
      two_channel_average <= pattern_latency_control[`AOC_W2_AVERAGE];
      frame_line_prbs_sel <= pattern_latency_control[`AOC_W2_FRAME_PRBS];
      data_line_pattern_sel <=
        pattern_latency_control[`AOC_W2_DATA_PAT_HI:`AOC_W2_DATA_PAT_LO];
      global_prbs_sel <= pattern_latency_control[`AOC_W2_GLOBAL_PRBS];
    end
  end

  // Source selection: power-down and disable win, then PRBS, then pattern
  // Off wins so a stopped interface never shows a pattern
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_source <= `AOC_SRC_OFF;
      frame_source <= `AOC_SRC_OFF;
    end else if (output_power_control[`AOC_W1_POWER_DOWN] ||
                 output_power_control[`AOC_W1_SERIAL_DISABLE]) begin
      data_source <= `AOC_SRC_OFF;
      frame_source <= `AOC_SRC_OFF;
    end else begin
      if (pattern_latency_control[`AOC_W2_GLOBAL_PRBS]) begin
        data_source <= `AOC_SRC_PRBS;
      end else if (pattern_active(
                   pattern_latency_control[`AOC_W2_DATA_PAT_HI:`AOC_W2_DATA_PAT_LO])) begin
        data_source <= `AOC_SRC_PATTERN;
      end else begin
        data_source <= `AOC_SRC_NORMAL;
      end
      if (pattern_latency_control[`AOC_W2_FRAME_PRBS]) begin
        frame_source <= `AOC_SRC_PRBS;
      end else if (pattern_active(
                   pattern_latency_control[`AOC_W2_FRAME_PAT_HI:`AOC_W2_FRAME_PAT_LO])) begin
        frame_source <= `AOC_SRC_PATTERN;
      end else begin
        frame_source <= `AOC_SRC_NORMAL;
      end
    end
  end

  // Word 3 controls and rate decode
  // An unused rate code gives zero lane bits and raises the unused flag
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serialization_rate <= `AOC_RATE_12X;
      lane_bit_count <= `AOC_BITS_12X;
      rate_code_unused <= 1'b0;
      digital_gain_enable <= 1'b0;
      digital_offset_enable <= 1'b0;
    end else begin
      serialization_rate <= serial_rate_gain_offset_control[`AOC_W3_RATE_HI:`AOC_W3_RATE_LO];
      lane_bit_count <=
        rate_bits(serial_rate_gain_offset_control[`AOC_W3_RATE_HI:`AOC_W3_RATE_LO]);
      rate_code_unused <= (rate_bits(
        serial_rate_gain_offset_control[`AOC_W3_RATE_HI:`AOC_W3_RATE_LO]) == 5'h00);
      digital_gain_enable <= serial_rate_gain_offset_control[`AOC_W3_GAIN_EN];
      digital_offset_enable <= serial_rate_gain_offset_control[`AOC_W3_OFFSET_EN];
    end
  end

  // Delay value and start pulse
  // The start pulse is re-timed so that it leaves a flip-flop
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      offset_start_delay <= 8'h00;
      offset_corr_start <= 1'b0;
    end else begin
      offset_start_delay <= delay_word;
      offset_corr_start <= delay_start;
    end
  end

endmodule

// *** rtl/aoc_start_delay.v ***
// Sample-counting delay from a transmit trigger to the start of offset correction
module aoc_start_delay (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Timing
  input wire sample_en,
  input wire trigger,
  input wire [7:0] delay,
  // Result
  output reg start,
  output reg busy
);

  reg [7:0] count;

  // A trigger restarts the count; zero delay starts at once
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
      busy <= 1'b0;
      start <= 1'b0;
    end else begin
      start <= 1'b0;
      if (trigger) begin
        if (delay == 8'h00) begin
          start <= 1'b1;
          busy <= 1'b0;
        end else begin
          count <= delay;
          busy <= 1'b1;
        end
      end else if (busy && sample_en) begin
        if (count == 8'h01) begin
          start <= 1'b1;
          busy <= 1'b0;
        end
        count <= count - 8'h01;
      end
    end
  end

endmodule

// *** shared/aoc_map.vh ***
// Register indices, field positions, reset values and counts for the output control bank
`ifndef AOC_MAP_VH
`define AOC_MAP_VH

// Register indices; the APB byte address is four times the index
`define AOC_IDX_OUTPUT_POWER 4'h1
`define AOC_IDX_PATTERN_LATENCY 4'h2
`define AOC_IDX_RATE_GAIN_OFFSET 4'h3
`define AOC_IDX_STATUS 4'h8

// Word 1 fields
`define AOC_W1_DOUBLE_RATE 14
`define AOC_W1_SERIAL_DISABLE 5
`define AOC_W1_POWER_DOWN 0

// Word 2 fields
`define AOC_W2_FRAME_PAT_HI 15
`define AOC_W2_FRAME_PAT_LO 13
`define AOC_W2_LOW_LATENCY 12
`define AOC_W2_AVERAGE 11
`define AOC_W2_FRAME_PRBS 10
`define AOC_W2_DATA_PAT_HI 9
`define AOC_W2_DATA_PAT_LO 7
`define AOC_W2_GLOBAL_PRBS 6
`define AOC_W2_DELAY_LO_HI 5
`define AOC_W2_DELAY_LO_LO 0

// Word 3 fields
`define AOC_W3_RATE_HI 15
`define AOC_W3_RATE_LO 13
`define AOC_W3_GAIN_EN 12
`define AOC_W3_DELAY_HI_HI 10
`define AOC_W3_DELAY_HI_LO 9
`define AOC_W3_OFFSET_EN 8

// Writable masks of the three words; all other bits read as zero
`define AOC_W1_MASK 16'h4021
`define AOC_W2_MASK 16'hffff
`define AOC_W3_MASK 16'hf700

// Reset values
`define AOC_W1_RESET 16'h0000
`define AOC_W2_RESET 16'h0000
`define AOC_W3_RESET 16'h0000

// Serialization rate codes and lane bit counts
`define AOC_RATE_12X 3'h0
`define AOC_RATE_14X 3'h1
`define AOC_RATE_16X 3'h4
`define AOC_BITS_12X 5'h0c
`define AOC_BITS_14X 5'h0e
`define AOC_BITS_16X 5'h10

// Output pattern encoding
`define AOC_PAT_NORMAL 3'h0
`define AOC_PAT_SYNC 3'h1
`define AOC_PAT_ALTERNATE 3'h2
`define AOC_PAT_CUSTOM 3'h3
`define AOC_PAT_ONES 3'h4
`define AOC_PAT_TOGGLE 3'h5
`define AOC_PAT_ZEROS 3'h6
`define AOC_PAT_RAMP 3'h7

// Data source codes driven to the output path
`define AOC_SRC_OFF 3'h0
`define AOC_SRC_NORMAL 3'h1
`define AOC_SRC_PATTERN 3'h2
`define AOC_SRC_PRBS 3'h3

// Default clocks per converter sample
`define AOC_SAMPLE_DIV 8'h02

`endif

// *** sim/aoc_output_control_properties.sv ***
// Port-level checker for the output control register bank
`include "aoc_map.vh"
module aoc_output_control_props (
  // Clock, reset and APB
  input wire core_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  // Decoded controls
  input wire double_rate_merge,
  input wire serial_output_disable,
  input wire serial_output_enable,
  input wire global_power_down,
  input wire [4:0] lane_bit_count,
  input wire [2:0] serialization_rate,
  input wire rate_code_unused,
  input wire [2:0] frame_line_pattern_sel,
  input wire frame_line_prbs_sel,
  input wire [2:0] data_line_pattern_sel,
  input wire global_prbs_sel,
  input wire [2:0] data_source,
  input wire [2:0] frame_source,
  input wire low_latency_bypass,
  input wire two_channel_average,
  input wire digital_gain_enable,
  input wire digital_offset_enable,
  input wire [7:0] offset_start_delay,
  input wire offset_corr_start
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Accepted writes per word and byte lane
  wire acc = psel && penable && pready && pwrite && !pslverr;
  wire w1_lo = acc && paddr == 12'h004 && pstrb[0];
  wire w1_hi = acc && paddr == 12'h004 && pstrb[1];
  wire w2_lo = acc && paddr == 12'h008 && pstrb[0];
  wire w2_hi = acc && paddr == 12'h008 && pstrb[1];
  wire w3_hi = acc && paddr == 12'h00c && pstrb[1];
  wire [4:0] lanes = serialization_rate == 3'h0 ? 5'h0c : serialization_rate == 3'h1 ? 5'h0e :
    serialization_rate == 3'h4 ? 5'h10 : 5'h00;
  property p_merge;
    w1_hi |-> ##2 double_rate_merge == $past(pwdata[14], 2);
  endproperty
  a_merge: assert property (p_merge) else $error("merge bit not applied");
  property p_pdn;
    w1_lo |-> ##2 {serial_output_disable, global_power_down} ==
      {$past(pwdata[5], 2), $past(pwdata[0], 2)};
  endproperty
  a_pdn: assert property (p_pdn) else $error("disable or power-down not applied");
  property p_off;
    serial_output_disable || global_power_down |->
      !serial_output_enable && data_source == `AOC_SRC_OFF && frame_source == `AOC_SRC_OFF;
  endproperty
  a_off: assert property (p_off) else $error("interface still running");
  property p_w2hi;
    w2_hi |-> ##2 {frame_line_pattern_sel, low_latency_bypass, two_channel_average,
      frame_line_prbs_sel} == $past(pwdata[15:10], 2);
  endproperty
  a_w2hi: assert property (p_w2hi) else $error("word 2 upper fields wrong");
  property p_gprbs;
    w2_lo |-> ##2 global_prbs_sel == $past(pwdata[6], 2);
  endproperty
  a_gprbs: assert property (p_gprbs) else $error("global prbs bit wrong");
  property p_src;
    serial_output_enable |-> data_source == (global_prbs_sel ? `AOC_SRC_PRBS :
      data_line_pattern_sel == 3'h0 ? `AOC_SRC_NORMAL : `AOC_SRC_PATTERN);
  endproperty
  a_src: assert property (p_src) else $error("data source wrong");
  property p_fprbs;
    frame_line_prbs_sel && serial_output_enable |-> frame_source == `AOC_SRC_PRBS;
  endproperty
  a_fprbs: assert property (p_fprbs) else $error("frame prbs not selected");
  property p_rate;
    lane_bit_count == lanes && rate_code_unused == (lanes == 5'h00);
  endproperty
  a_rate: assert property (p_rate) else $error("rate decode wrong");
  property p_w3;
    w3_hi |-> ##2 {digital_gain_enable, offset_start_delay[7:6], digital_offset_enable} ==
      {$past(pwdata[12], 2), $past(pwdata[10:8], 2)};
  endproperty
  a_w3: assert property (p_w3) else $error("word 3 fields wrong");
  property p_pulse;
    offset_corr_start |=> !offset_corr_start;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  c_w1: cover property (w1_hi);
  c_err: cover property (psel && penable && pready && pslverr);
  c_start: cover property (offset_corr_start);
endmodule
bind aoc_output_control aoc_output_control_props u_props (.core_clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .double_rate_merge,
  .serial_output_disable, .serial_output_enable, .global_power_down, .lane_bit_count,
  .serialization_rate, .rate_code_unused, .frame_line_pattern_sel, .frame_line_prbs_sel,
  .data_line_pattern_sel, .global_prbs_sel, .data_source, .frame_source, .low_latency_bypass,
  .two_channel_average, .digital_gain_enable, .digital_offset_enable, .offset_start_delay,
  .offset_corr_start);

// *** sim/tb_top.sv ***
// Self-checking bench for the output control register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0;
  logic rst_n, psel, penable, pwrite, transmit_trigger, err, pready, pslverr;
  logic double_rate_merge, serial_output_disable, serial_output_enable, global_power_down;
  logic rate_code_unused, frame_line_prbs_sel, global_prbs_sel, low_latency_bypass;
  logic two_channel_average, digital_gain_enable, digital_offset_enable, offset_corr_start;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [31:0] seed = 32'hd0fb;
  logic [3:0] pstrb;
  logic [4:0] lane_bit_count;
  logic [2:0] serialization_rate, frame_line_pattern_sel, data_line_pattern_sel;
  logic [2:0] data_source, frame_source;
  logic [7:0] offset_start_delay;
  logic [15:0] m [1:3];
  logic [15:0] mk [1:3];
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int t, w;
  aoc_output_control #(.SAMPLE_DIV(2)) dut (.core_clk, .rst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .transmit_trigger,
    .double_rate_merge, .serial_output_disable, .serial_output_enable, .global_power_down,
    .lane_bit_count, .serialization_rate, .rate_code_unused, .frame_line_pattern_sel,
    .frame_line_prbs_sel, .data_line_pattern_sel, .global_prbs_sel, .data_source,
    .frame_source, .low_latency_bypass, .two_channel_average, .digital_gain_enable,
    .digital_offset_enable, .offset_start_delay, .offset_corr_start);
  // Clock
  always #12.5 core_clk = ~core_clk;
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [2:0] exp_src(input logic [2:0] pat, input logic prbs);
    if (m[1][5] || m[1][0]) return 3'h0;
    if (prbs) return 3'h3;
    return (pat != 3'h0) ? 3'h2 : 3'h1;
  endfunction
  function automatic logic [4:0] exp_lanes(input logic [2:0] c);
    case (c)
      3'h0: return 5'h0c;
      3'h1: return 5'h0e;
      3'h4: return 5'h10;
      default: return 5'h00;
    endcase
  endfunction
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, waiting for pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s);
    logic [15:0] lm;
    lm = {{8{s[1]}}, {8{s[0]}}};
    apb(12'(i * 4), 1'h1, {16'h0, d}, s);
    m[i] = ((m[i] & ~lm) | (d & lm)) & mk[i];
    chk("wr_err", 1'h0, err);
  endtask
  task automatic rdchk(input int i);
    apb(12'(i * 4), 1'h0, 32'h0, 4'h0);
    chk("rdata", {16'h0, m[i]}, rd);
  endtask
  task automatic outs();
    repeat (2) @(posedge core_clk);
    chk("merge", m[1][14], double_rate_merge);
    chk("sdis", m[1][5], serial_output_disable);
    chk("pdn", m[1][0], global_power_down);
    chk("sen", !(m[1][5] || m[1][0]), serial_output_enable);
    chk("fpat", m[2][15:13], frame_line_pattern_sel);
    chk("lowlat", m[2][12], low_latency_bypass);
    chk("avg", m[2][11], two_channel_average);
    chk("fsrc", exp_src(m[2][15:13], m[2][10]), frame_source);
    chk("fprbs", m[2][10], frame_line_prbs_sel);
    chk("dpat", m[2][9:7], data_line_pattern_sel);
    chk("gprbs", m[2][6], global_prbs_sel);
    chk("dsrc", exp_src(m[2][9:7], m[2][6]), data_source);
    chk("delay", {m[3][10:9], m[2][5:0]}, offset_start_delay);
    chk("lanes", exp_lanes(m[3][15:13]), lane_bit_count);
    chk("rate", m[3][15:13], serialization_rate);
    chk("unused", exp_lanes(m[3][15:13]) == 5'h00, rate_code_unused);
    chk("gain", m[3][12], digital_gain_enable);
    chk("offs", m[3][8], digital_offset_enable);
  endtask
  task automatic trig(output int k);
    @(posedge core_clk);
    transmit_trigger <= 1'h1;
    k = 0;
    while (offset_corr_start !== 1'h1 && k < 300) begin
      @(posedge core_clk);
      k++;
      if (k == 4) transmit_trigger <= 1'h0;
    end
  endtask
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, transmit_trigger} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    mk = '{16'h4021, 16'hffff, 16'hf700};
    m = '{16'h0000, 16'h0000, 16'h0000};
    repeat (8) @(posedge core_clk);
    rst_n <= 1'h1;
    for (int i = 1; i < 4; i++) rdchk(i);
    outs();
    wr(1, 16'h4035, 4'h3);
    rdchk(1);
    $display("test reset done");
    wr(1, 16'h0014, 4'h3);
    for (int c = 0; c < 8; c++) begin
      wr(2, {c[2:0], 3'h0, c[2:0], 7'h00}, 4'h3);
      wr(3, {c[2:0], 13'h0000}, 4'h2);
      outs();
    end
    $display("test codes done");
    for (int j = 0; j < 60; j++) begin
      r = rnd();
      w = 1 + r[7:0] % 3;
      wr(w, (r[23:8] & mk[w]) | (w == 1 ? 16'h0014 : 16'h0000), r[27:24]);
      rdchk(w);
      outs();
    end
    $display("test random done");
    apb(12'h010, 1'h0, 32'h0, 4'h0);
    chk("unmapped_err", 1'h1, err);
    chk("unmapped_rd", 32'h0, rd);
    apb(12'h006, 1'h1, 32'hffff, 4'h3);
    chk("misaligned_err", 1'h1, err);
    for (int i = 1; i < 4; i++) rdchk(i);
    $display("test refusal done");
    wr(1, 16'h0014, 4'h3);
    wr(2, 16'h0003, 4'h3);
    wr(3, 16'h0100, 4'h2);
    trig(t);
    chk("start_short", 1'h1, t >= 4 && t <= 16);
    wr(3, 16'h0300, 4'h2);
    trig(t);
    chk("start_long", 1'h1, t >= 128 && t <= 142);
    wr(3, 16'h0000, 4'h2);
    trig(t);
    chk("start_off", 32'd300, t);
    apb(12'h020, 1'h0, 32'h0, 4'h0);
    chk("status", 32'h00000200, rd);
    chk("status_err", 1'h0, err);
    $display("test trigger done");
    print_verdict();
  end
endmodule
